// ### shared/timer8_pkg.sv
/*
 register indices, field positions, encodings and reset values of the 8-bit timer block.
 assumes an AXI4-Lite master with 32-bit data; byte address is four times the index.
*/
`default_nettype none
package timer8_pkg;
  // ****************************************
  // register map (index, byte address = 4 * index)
  // ****************************************
  localparam int unsigned ADDR_W        = 9;
  localparam int unsigned IDX_W         = 7;
  localparam logic [6:0]  IDX_FLAGS     = 7'h15;
  localparam logic [6:0]  IDX_CONTROL_A = 7'h24;
  localparam logic [6:0]  IDX_CONTROL_B = 7'h25;
  localparam logic [6:0]  IDX_COUNT     = 7'h26;
  localparam logic [6:0]  IDX_CMP_A     = 7'h27;
  localparam logic [6:0]  IDX_CMP_B     = 7'h28;
  localparam logic [6:0]  IDX_MASK      = 7'h6e;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CB_FORCE_A = 7;
  localparam int unsigned CB_WAVE_HI = 3;
  localparam int unsigned CA_OM_A    = 6;
  localparam int unsigned CA_OM_B    = 4;
  localparam int unsigned FLAG_OVF   = 0;
  localparam int unsigned FLAG_CMP_A = 1;
  localparam int unsigned FLAG_CMP_B = 2;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W    = 10;
  localparam logic [9:0] PM_8        = 10'h007;
  localparam logic [9:0] PM_64       = 10'h03f;
  localparam logic [9:0] PM_256      = 10'h0ff;
  localparam logic [9:0] PM_1024     = 10'h3ff;
  localparam logic [1:0] OM_OFF      = 2'h0;
  localparam logic [1:0] OM_TOGGLE   = 2'h1;
  localparam logic [1:0] OM_CLEAR    = 2'h2;
  localparam logic [1:0] OM_SET      = 2'h3;
  localparam logic [2:0] WM_CTC      = 3'h2;
  localparam logic [2:0] WM_PC_OCRA  = 3'h5;
  localparam logic [2:0] WM_FAST_TOP = 3'h7;
  localparam logic [7:0] COUNT_MAX   = 8'hff;
  localparam logic [7:0] COUNT_BOT   = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### hdl/timer8_ctrl.sv
/*
 8-bit timer/counter: clock select, counter, two compare channels, force strobes,
 interrupt mask and flags, AXI4-Lite register slave.
 assumes pins and vector acknowledges synchronous to aclk; one aclk is the i/o clock.
*/
// Operation
// - force bit a in non-pwm mode makes output a act on its mode now
// - a force strobe sets no flag and never clears the counter
// - force bit b in non-pwm mode acts on output b, no flag, no clear
// - force bits are write-only strobes reading zero, ignored in pwm modes
// - reserved bits of control b, mask and flags read zero
// - clock select picks stop, divided i/o clock, or external pin edge
// - external pin edges count even when the pin drives as an output
// - counter register is readable and writable at any time
// - a counter write blocks compare matches on the next timer tick
// - both compare values are compared continuously, feeding flags and outputs
// - interrupt needs enable bit, flag and global enable all set
// - compare b flag sets on match, clears by vector or written one
// - compare a flag sets on match, clears by vector or written one
// - overflow flag sets at the mode's overflow point, clears likewise
// - wave mode bits choose normal, phase correct, ctc or fast pwm and top
// - non-pwm output mode gives off, toggle, clear or set on match
`timescale 1ns/1ps
`default_nettype none
module timer8_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [8:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [8:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ext_count_pin,
  input  wire logic        cpu_irq_enable,
  input  wire logic [2:0]  vector_ack,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             wave_out_en_a,
  output logic             wave_out_en_b,
  output logic             irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0][1:0] om;
    logic [1:0]      wm_lo;
    logic            wm_hi;
    logic [2:0]      cs;
    logic [7:0]      count;
    logic [1:0][7:0] cmp;
    logic [2:0]      mask;
    logic [2:0]      flags;
    logic [9:0]      presc;
    logic            ext_prev;
    logic            block;
    logic            up;
    logic [1:0]      wave;
    logic            aw_ok;
    logic [6:0]      aw_idx;
    logic            w_ok;
    logic [7:0]      w_byte;
    logic            w_lane0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
  } st_t;

  st_t        q;
  st_t        d;
  logic [2:0] wm;
  logic       pwm;
  logic       pc;
  logic       fast;
  logic [7:0] top;
  logic       tick;
  logic [7:0] count_nx;
  logic       up_nx;
  logic       ovf;
  logic       bottom;
  logic       do_wr;
  logic       wr_cb;
  logic       wr_count;
  logic       wr_flags;
  logic [6:0] ar_idx;
  logic [1:0] match;
  logic [1:0] force_ev;
  logic [1:0] wave_nx;
  logic [1:0] wave_en;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // pwm outputs follow their own rules; force only exists for non-pwm modes
  function automatic logic wave_step(
    input logic       cur,
    input logic [1:0] om,
    input logic       hit,
    input logic       bot,
    input logic       dn,
    input logic       is_pwm,
    input logic       is_pc,
    input logic       tog_ok
  );
    logic r;
    r = cur;
    if (!is_pwm)
    begin
      if (hit)
      begin
        case (om)
          timer8_pkg::OM_TOGGLE: r = ~cur;
          timer8_pkg::OM_CLEAR:  r = 1'b0;
          timer8_pkg::OM_SET:    r = 1'b1;
          default:               r = cur;
        endcase
      end
    end
    else if (om[1])
    begin
      if (is_pc)
      begin
        if (hit)
          r = dn ? ~om[0] : om[0];
      end
      else if (hit)
        r = om[0];
      else if (bot)
        r = ~om[0];
    end
    else if (om == timer8_pkg::OM_TOGGLE && tog_ok && hit)
      r = ~cur;
    return r;
  endfunction

  // ****************************************
  // mode decode and timer clock
  // ****************************************
  assign wm   = {q.wm_hi, q.wm_lo};
  assign pwm  = wm[0];
  assign fast = wm[1] & wm[0];
  assign pc   = wm[0] & ~wm[1];
  assign top  = (wm == timer8_pkg::WM_CTC || wm == timer8_pkg::WM_PC_OCRA ||
                 wm == timer8_pkg::WM_FAST_TOP) ? q.cmp[0] : timer8_pkg::COUNT_MAX;

  // the pin is sampled as is, so software driving it as an output still counts
  always_comb
  begin
    case (q.cs)
      timer8_pkg::CS_DIV1:     tick = 1'b1;
      timer8_pkg::CS_DIV8:     tick = (q.presc & timer8_pkg::PM_8) == '0;
      timer8_pkg::CS_DIV64:    tick = (q.presc & timer8_pkg::PM_64) == '0;
      timer8_pkg::CS_DIV256:   tick = (q.presc & timer8_pkg::PM_256) == '0;
      timer8_pkg::CS_DIV1024:  tick = (q.presc & timer8_pkg::PM_1024) == '0;
      timer8_pkg::CS_EXT_FALL: tick = q.ext_prev & ~ext_count_pin;
      timer8_pkg::CS_EXT_RISE: tick = ~q.ext_prev & ext_count_pin;
      default:                 tick = 1'b0;
    endcase
  end

  always_comb
  begin
    count_nx = q.count + 8'h01;
    up_nx    = q.up;
    ovf      = 1'b0;
    if (pc)
    begin
      if (q.up && q.count == top)
      begin
        up_nx    = 1'b0;
        count_nx = q.count - 8'h01;
      end
      else if (!q.up)
      begin
        if (q.count == timer8_pkg::COUNT_BOT)
        begin
          up_nx    = 1'b1;
          ovf      = 1'b1;
        end
        else
          count_nx = q.count - 8'h01;
      end
    end
    else
    begin
      up_nx = 1'b1;
      if (q.count == top)
        count_nx = timer8_pkg::COUNT_BOT;
      ovf = (wm == timer8_pkg::WM_FAST_TOP) ? (q.count == top) :
                                              (q.count == timer8_pkg::COUNT_MAX);
    end
  end

  assign bottom = fast & tick & (count_nx == timer8_pkg::COUNT_BOT);

  // ****************************************
  // register access decode
  // ****************************************
  assign do_wr    = q.aw_ok & q.w_ok & ~q.bvalid;
  assign wr_cb    = do_wr & q.w_lane0 & (q.aw_idx == timer8_pkg::IDX_CONTROL_B);
  assign wr_count = do_wr & q.w_lane0 & (q.aw_idx == timer8_pkg::IDX_COUNT);
  assign wr_flags = do_wr & q.w_lane0 & (q.aw_idx == timer8_pkg::IDX_FLAGS);
  assign ar_idx   = araddr[timer8_pkg::ADDR_W-1:2];

  // ****************************************
  // compare channels
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    assign match[ch]    = tick & ~q.block & (q.count == q.cmp[ch]);
    assign force_ev[ch] = wr_cb & ~pwm &
                          q.w_byte[timer8_pkg::CB_FORCE_A - ch];
    assign wave_nx[ch]  = wave_step(q.wave[ch], q.om[ch], match[ch] | force_ev[ch], bottom,
                                    ~q.up, pwm, pc, q.wm_hi & (ch == 0));
    assign wave_en[ch]  = q.om[ch] != timer8_pkg::OM_OFF;
  end

  // force never reaches the flags or the counter
  assign flag_set = {match[1], match[0], tick & ovf};
  assign flag_clr = vector_ack | (wr_flags ? q.w_byte[2:0] : 3'h0);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d          = q;
    d.presc    = q.presc + 10'h001;
    d.ext_prev = ext_count_pin;
    d.wave     = wave_nx;
    d.flags    = (q.flags & ~flag_clr) | flag_set; // a set in the clearing cycle wins
    if (tick)
    begin
      d.count = count_nx;
      d.up    = up_nx;
      d.block = 1'b0;
    end
    if (do_wr)
    begin
      d.bvalid = 1'b1;
      d.bresp  = timer8_pkg::RESP_OKAY;
      case (q.aw_idx)
        timer8_pkg::IDX_CONTROL_A:
        begin
          if (q.w_lane0)
          begin
            d.om[0] = q.w_byte[timer8_pkg::CA_OM_A +: 2];
            d.om[1] = q.w_byte[timer8_pkg::CA_OM_B +: 2];
            d.wm_lo = q.w_byte[1:0];
          end
        end
        timer8_pkg::IDX_CONTROL_B:
        begin
          if (q.w_lane0)
          begin
            d.wm_hi = q.w_byte[timer8_pkg::CB_WAVE_HI];
            d.cs    = q.w_byte[2:0];
          end
        end
        timer8_pkg::IDX_COUNT:
        begin
          if (q.w_lane0)
          begin
            d.count = q.w_byte;
            d.block = 1'b1;
          end
        end
        timer8_pkg::IDX_CMP_A:
        begin
          if (q.w_lane0)
            d.cmp[0] = q.w_byte;
        end
        timer8_pkg::IDX_CMP_B:
        begin
          if (q.w_lane0)
            d.cmp[1] = q.w_byte;
        end
        timer8_pkg::IDX_MASK:
        begin
          if (q.w_lane0)
            d.mask = q.w_byte[2:0];
        end
        timer8_pkg::IDX_FLAGS: d.bresp = timer8_pkg::RESP_OKAY;
        default:               d.bresp = timer8_pkg::RESP_SLVERR;
      endcase
      d.aw_ok = 1'b0;
      d.w_ok  = 1'b0;
    end
    if (awvalid && awready)
    begin
      d.aw_ok  = 1'b1;
      d.aw_idx = awaddr[timer8_pkg::ADDR_W-1:2];
    end
    if (wvalid && wready)
    begin
      d.w_ok    = 1'b1;
      d.w_byte  = wdata[7:0];
      d.w_lane0 = wstrb[0];
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;
    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      d.rvalid = 1'b1;
      d.rresp  = timer8_pkg::RESP_OKAY;
      case (ar_idx)
        timer8_pkg::IDX_CONTROL_A: d.rdata = {q.om[0], q.om[1], 2'h0, q.wm_lo};
        timer8_pkg::IDX_CONTROL_B: d.rdata = {4'h0, q.wm_hi, q.cs};
        timer8_pkg::IDX_COUNT:     d.rdata = q.count;
        timer8_pkg::IDX_CMP_A:     d.rdata = q.cmp[0];
        timer8_pkg::IDX_CMP_B:     d.rdata = q.cmp[1];
        timer8_pkg::IDX_MASK:      d.rdata = {5'h00, q.mask};
        timer8_pkg::IDX_FLAGS:     d.rdata = {5'h00, q.flags};
        default:
        begin
          d.rdata = timer8_pkg::REG_RESET;
          d.rresp = timer8_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign awready       = ~q.aw_ok & ~q.bvalid;
  assign wready        = ~q.w_ok & ~q.bvalid;
  assign arready       = ~q.rvalid;
  assign bvalid        = q.bvalid;
  assign bresp         = q.bresp;
  assign rvalid        = q.rvalid;
  assign rresp         = q.rresp;
  assign rdata         = {24'h000000, q.rdata};
  assign wave_out_a    = q.wave[0];
  assign wave_out_b    = q.wave[1];
  assign wave_out_en_a = wave_en[0];
  assign wave_out_en_b = wave_en[1];
  assign irq           = cpu_irq_enable & |(q.flags & q.mask);

  // ****************************************
  // checks
  // ****************************************
  sequence s_force_a_alone;
    force_ev[0] && !match[0];
  endsequence

  property p_force_a_toggle;
    @(posedge aclk) disable iff (!aresetn)
    (s_force_a_alone and (q.om[0] == timer8_pkg::OM_TOGGLE)) |=> q.wave[0] != $past(q.wave[0]);
  endproperty
  a_force_a_toggle: assert property (p_force_a_toggle) else $error("force a no toggle");

  property p_force_no_flag;
    @(posedge aclk) disable iff (!aresetn)
    (s_force_a_alone and !q.flags[timer8_pkg::FLAG_CMP_A]) |=> !q.flags[timer8_pkg::FLAG_CMP_A];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force a set a flag");

  property p_force_b_set;
    @(posedge aclk) disable iff (!aresetn)
    (force_ev[1] && q.om[1] == timer8_pkg::OM_SET) |=> q.wave[1];
  endproperty
  a_force_b_set: assert property (p_force_b_set) else $error("force b did not set");

  property p_pwm_no_force;
    @(posedge aclk) disable iff (!aresetn)
    (wr_cb && pwm && !tick) |=> $stable(q.wave);
  endproperty
  a_pwm_no_force: assert property (p_pwm_no_force) else $error("force acted in pwm");

  property p_mask_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && ar_idx == timer8_pkg::IDX_MASK) |=> rvalid && rdata[7:3] == 5'h00;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("mask reserved set");

  property p_div8_spacing;
    @(posedge aclk) disable iff (!aresetn)
    (tick && q.cs == timer8_pkg::CS_DIV8) |=> (!tick || q.cs != timer8_pkg::CS_DIV8)[*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("div8 ticks too close");

  property p_ext_rise_count;
    @(posedge aclk) disable iff (!aresetn)
    (q.cs == timer8_pkg::CS_EXT_RISE && !q.ext_prev && ext_count_pin && !wr_count && !pc &&
     q.count != top) |=> q.count == $past(q.count) + 8'h01;
  endproperty
  a_ext_rise_count: assert property (p_ext_rise_count) else $error("rise not counted");

  property p_block_match;
    @(posedge aclk) disable iff (!aresetn)
    (q.block && tick && q.count == q.cmp[0] && !force_ev[0] &&
     q.wave[0] == 1'b0 && q.om[0] == timer8_pkg::OM_SET && !pwm) |=> !q.wave[0];
  endproperty
  a_block_match: assert property (p_block_match) else $error("blocked match acted");

  property p_match_b_flag;
    @(posedge aclk) disable iff (!aresetn)
    match[1] |=> q.flags[timer8_pkg::FLAG_CMP_B];
  endproperty
  a_match_b_flag: assert property (p_match_b_flag) else $error("compare b flag lost");

  property p_ovf_w1c;
    @(posedge aclk) disable iff (!aresetn)
    (wr_flags && q.w_byte[timer8_pkg::FLAG_OVF] && !flag_set[timer8_pkg::FLAG_OVF])
      |=> !q.flags[timer8_pkg::FLAG_OVF];
  endproperty
  a_ovf_w1c: assert property (p_ovf_w1c) else $error("overflow flag not cleared");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
    ((q.flags & q.mask) == 3'h0 || !cpu_irq_enable) |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

  property p_reset_clear;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> q.cs == timer8_pkg::CS_STOP && q.mask == 3'h0 && q.flags == 3'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear");
endmodule
`default_nettype wire

// ### verif/testbench.sv
/*
 self-checking bench for timer8_ctrl: register access, clock select, force strobes, flags, irq.
 assumes the dut is the only block on its bus; the bench drives every dut input itself.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk;
  logic        aresetn;
  logic [8:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [8:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        ext_count_pin;
  logic        cpu_irq_enable;
  logic [2:0]  vector_ack;
  logic        wave_out_a;
  logic        wave_out_b;
  logic        wave_out_en_a;
  logic        wave_out_en_b;
  logic        irq;
  int          error_cnt;
  int          comparisons;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [31:0] v;
  logic        exp_a;
  logic        exp_b;
  logic [1:0]  om_seq [4];
  int          div_tab [6];

  timer8_ctrl dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .ext_count_pin, .cpu_irq_enable, .vector_ack, .wave_out_a, .wave_out_b,
    .wave_out_en_a, .wave_out_en_b, .irq
  );

  always #5 aclk = ~aclk;

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic complete_run;
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic nxt(input logic cur, input logic [1:0] om);
    case (om)
      timer8_pkg::OM_TOGGLE: return ~cur;
      timer8_pkg::OM_CLEAR:  return 1'b0;
      timer8_pkg::OM_SET:    return 1'b1;
      default:               return cur;
    endcase
  endfunction

  // ****************************************
  // bus tasks
  // ****************************************
  // address and data offered together; each released on its own ready
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 100) error_cnt++;
  endtask

  task automatic rd_reg(input logic [6:0] idx);
    int n;
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 100) error_cnt++;
  endtask

  task automatic rchk(input logic [6:0] idx, input logic [7:0] e, input string nm);
    rd_reg(idx);
    chk(nm, rd, {24'h0, e});
  endtask

  // the flag may need a whole counter lap, so the wait is bounded at 300 cycles
  task automatic wait_irq(input string nm);
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    chk(nm, 32'(irq), 32'h1);
  endtask

  task automatic ack(input logic [2:0] a);
    @(posedge aclk);
    vector_ack <= a;
    @(posedge aclk);
    vector_ack <= 3'h0;
    @(posedge aclk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 9'h000;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 9'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    ext_count_pin = 1'b0;
    cpu_irq_enable = 1'b0;
    vector_ack = 3'h0;
    error_cnt = 0;
    comparisons = 0;
    om_seq = '{timer8_pkg::OM_CLEAR, timer8_pkg::OM_SET, timer8_pkg::OM_TOGGLE,
               timer8_pkg::OM_TOGGLE};
    div_tab = '{0, 1, 8, 64, 256, 1024};
    void'($urandom(32'h6bd669c8));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(timer8_pkg::IDX_CONTROL_B, 8'h00, "control_b reset");
    rchk(timer8_pkg::IDX_MASK, 8'h00, "mask reset");
    rchk(timer8_pkg::IDX_FLAGS, 8'h00, "flags reset");
    chk("irq reset", 32'(irq), 32'h0);
    rd_reg(7'h01);
    chk("unmapped rresp", 32'(rs), 32'(timer8_pkg::RESP_SLVERR));
    wr(7'h01, 8'hff);
    chk("unmapped bresp", 32'(rs), 32'(timer8_pkg::RESP_SLVERR));
    wr(timer8_pkg::IDX_MASK, 8'hff);
    rchk(timer8_pkg::IDX_MASK, 8'h07, "mask reserved");
    wr(timer8_pkg::IDX_MASK, 8'h00);
    wr(timer8_pkg::IDX_CONTROL_B, 8'hf8);
    rchk(timer8_pkg::IDX_CONTROL_B, 8'h08, "control_b strobes");
    wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
    repeat (8)
    begin
      v = $urandom;
      wr(timer8_pkg::IDX_COUNT, v[7:0]);
      wr(timer8_pkg::IDX_CMP_A, v[15:8]);
      wr(timer8_pkg::IDX_CMP_B, v[23:16]);
      rchk(timer8_pkg::IDX_COUNT, v[7:0], "count rw");
      rchk(timer8_pkg::IDX_CMP_A, v[15:8], "compare_a rw");
      rchk(timer8_pkg::IDX_CMP_B, v[23:16], "compare_b rw");
    end
    // forced compares with the timer stopped: count and flags must not move
    wr(timer8_pkg::IDX_COUNT, 8'h5a);
    exp_a = 1'b0;
    exp_b = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(timer8_pkg::IDX_CONTROL_A, {om_seq[i], om_seq[3 - i], 4'h0});
      chk("output enables", 32'({wave_out_en_a, wave_out_en_b}), 32'h3);
      wr(timer8_pkg::IDX_CONTROL_B, 8'hc0);
      exp_a = nxt(exp_a, om_seq[i]);
      exp_b = nxt(exp_b, om_seq[3 - i]);
      chk("forced wave a", 32'(wave_out_a), 32'(exp_a));
      chk("forced wave b", 32'(wave_out_b), 32'(exp_b));
    end
    rchk(timer8_pkg::IDX_FLAGS, 8'h00, "force flags");
    rchk(timer8_pkg::IDX_COUNT, 8'h5a, "force count");
    wr(timer8_pkg::IDX_CONTROL_A, {timer8_pkg::OM_CLEAR, timer8_pkg::OM_TOGGLE, 4'h3});
    wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
    // the next write breaks the software rule on purpose, to show pwm ignores the strobes
    wr(timer8_pkg::IDX_CONTROL_B, 8'hc0);
    chk("pwm force a", 32'(wave_out_a), 32'h1);
    chk("pwm force b", 32'(wave_out_b), 32'h0);
    wr(timer8_pkg::IDX_CONTROL_A, 8'h00);
    // prescaled rates: about 20 ticks each, bus latency adds a few at divide by one
    for (int k = 1; k < 6; k++)
    begin
      wr(timer8_pkg::IDX_COUNT, 8'h00);
      wr(timer8_pkg::IDX_CONTROL_B, 8'(k));
      repeat (20 * div_tab[k]) @(posedge aclk);
      wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
      rd_reg(timer8_pkg::IDX_COUNT);
      chk("prescaled count", 32'(rd >= 19 && rd <= 25), 32'h1);
      repeat (50) @(posedge aclk);
      rchk(timer8_pkg::IDX_COUNT, rd[7:0], "stopped count");
    end
    wr(timer8_pkg::IDX_COUNT, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(timer8_pkg::IDX_CONTROL_B, k ? 8'(timer8_pkg::CS_EXT_FALL) : 8'(timer8_pkg::CS_EXT_RISE));
      repeat (5)
      begin
        @(posedge aclk);
        ext_count_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        ext_count_pin <= 1'b0;
        repeat (2) @(posedge aclk);
      end
      wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
      rchk(timer8_pkg::IDX_COUNT, 8'(5 * (k + 1)), "pin count");
    end
    // interrupt sources one by one
    wr(timer8_pkg::IDX_FLAGS, 8'h07);
    wr(timer8_pkg::IDX_MASK, 8'h07);
    cpu_irq_enable <= 1'b1;
    wr(timer8_pkg::IDX_CMP_A, 8'h1e);
    wr(timer8_pkg::IDX_CMP_B, 8'h50);
    wr(timer8_pkg::IDX_COUNT, 8'h0a);
    wr(timer8_pkg::IDX_CONTROL_B, 8'(timer8_pkg::CS_DIV1));
    wait_irq("irq compare a");
    rchk(timer8_pkg::IDX_FLAGS, 8'h02, "flag a");
    ack(3'h2);
    chk("irq after ack a", 32'(irq), 32'h0);
    wait_irq("irq compare b");
    rchk(timer8_pkg::IDX_FLAGS, 8'h04, "flag b");
    wr(timer8_pkg::IDX_FLAGS, 8'h04);
    rchk(timer8_pkg::IDX_FLAGS, 8'h00, "flag b cleared");
    wait_irq("irq overflow");
    rchk(timer8_pkg::IDX_FLAGS, 8'h01, "flag overflow");
    ack(3'h1);
    chk("irq after ack ovf", 32'(irq), 32'h0);
    wr(timer8_pkg::IDX_MASK, 8'h00);
    repeat (300) @(posedge aclk);
    chk("irq masked", 32'(irq), 32'h0);
    rchk(timer8_pkg::IDX_FLAGS, 8'h07, "all flags");
    wr(timer8_pkg::IDX_MASK, 8'h07);
    chk("irq unmasked", 32'(irq), 32'h1);
    cpu_irq_enable <= 1'b0;
    @(posedge aclk);
    chk("irq global off", 32'(irq), 32'h0);
    // a counter write equal to compare a must not match on the following tick;
    // the timer is stopped first so the flag clear cannot race a running count
    wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
    wr(timer8_pkg::IDX_CONTROL_A, {timer8_pkg::OM_CLEAR, 6'h00});
    wr(timer8_pkg::IDX_CONTROL_B, 8'h80);
    wr(timer8_pkg::IDX_CONTROL_A, {timer8_pkg::OM_SET, 6'h00});
    chk("cleared wave a", 32'(wave_out_a), 32'h0);
    wr(timer8_pkg::IDX_CMP_A, 8'h40);
    wr(timer8_pkg::IDX_COUNT, 8'h40);
    wr(timer8_pkg::IDX_FLAGS, 8'h07);
    wr(timer8_pkg::IDX_CONTROL_B, 8'(timer8_pkg::CS_DIV1));
    repeat (100) @(posedge aclk);
    rd_reg(timer8_pkg::IDX_FLAGS);
    chk("blocked match", 32'(rd[1]), 32'h0);
    chk("blocked wave a", 32'(wave_out_a), 32'h0);
    wr(timer8_pkg::IDX_COUNT, 8'h3c);
    repeat (20) @(posedge aclk);
    rd_reg(timer8_pkg::IDX_FLAGS);
    chk("unblocked match", 32'(rd[1]), 32'h1);
    chk("unblocked wave a", 32'(wave_out_a), 32'h1);
    // clear on match with compare a as top: count stays at or below it, no overflow
    wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
    wr(timer8_pkg::IDX_CONTROL_A, 8'(timer8_pkg::WM_CTC));
    wr(timer8_pkg::IDX_CMP_A, 8'h10);
    wr(timer8_pkg::IDX_COUNT, 8'h00);
    wr(timer8_pkg::IDX_FLAGS, 8'h07);
    wr(timer8_pkg::IDX_CONTROL_B, 8'(timer8_pkg::CS_DIV1));
    repeat (300) @(posedge aclk);
    wr(timer8_pkg::IDX_CONTROL_B, 8'h00);
    rd_reg(timer8_pkg::IDX_COUNT);
    chk("ctc top", 32'(rd <= 32'h10), 32'h1);
    rchk(timer8_pkg::IDX_FLAGS, 8'h02, "ctc flags");
    complete_run;
  end

  initial
  begin
    // the divide by 1024 pass dominates; this is well above the whole run
    #500_000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
